// ---- ragc_regs.v ----
// right agc timing, adc path and bus condition registers
//
// What this block does
// - attack multiplier code n scales baseline attack by two to the n.
// - decay source bit: 0 legacy register 29, 1 new decay register.
// - baseline decay codes give 50, 150, 250, 350 ms.
// - decay multiplier code n scales baseline decay by two to the n.
// - decay time capped by decimation ratio, 4 s up to 22.4 s.
// - left highpass uses programmable coefficients when its bit is 1.
// - right highpass uses programmable coefficients when its bit is 1.
// - decimation field picks digital or analog microphone per channel.
// - effects filter follows adc when bit set and both dacs off.
// - bus error detector active when its disable bit is 0.
// - bus error status sets on error and clears on read.
// - baseline attack codes give 7, 8, 10, 11 ms.
// - attack source bit: 0 legacy register 29, 1 new attack register.
`timescale 1ns/1ps
`include "ragc_defs.vh"
module ragc_regs (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [6:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    input wire [23:0] i_legacy_attack_ms,
    input wire [23:0] i_legacy_decay_ms,
    input wire [3:0] i_adc_decimation_ratio,
    input wire i_dacs_powered_down,
    input wire i_bus_error,
    output reg [7:0] o_rdata,
    output reg [23:0] o_attack_ms,
    output reg [23:0] o_decay_ms,
    output reg o_left_hpf_prog,
    output reg o_right_hpf_prog,
    output reg o_left_analog_mic,
    output reg o_right_analog_mic,
    output reg o_effects_after_adc,
    output reg o_bus_error_clear
);
    reg [7:0] attack_reg;
    reg [7:0] decay_reg;
    reg [7:0] path_reg;
    reg err_flag;
    reg err_meta;
    reg err_sync;
    reg [15:0] atk_base;
    reg [15:0] dcy_base;
    reg [23:0] cap_ms;
    reg [23:0] next_decay;
    reg [23:0] capped;
    wire [23:0] atk_scaled;
    wire [23:0] dcy_scaled;
    wire det_on;

    assign det_on = ~path_reg[`RAGC_DET_OFF_BIT];

    // baseline time lookups
    always @* begin
        case (attack_reg[`RAGC_BASE_HI:`RAGC_BASE_LO])
            2'h0: atk_base = `RAGC_ATK_MS0;
            2'h1: atk_base = `RAGC_ATK_MS1;
            2'h2: atk_base = `RAGC_ATK_MS2;
            default: atk_base = `RAGC_ATK_MS3;
        endcase
        case (decay_reg[`RAGC_BASE_HI:`RAGC_BASE_LO])
            2'h0: dcy_base = `RAGC_DCY_MS0;
            2'h1: dcy_base = `RAGC_DCY_MS1;
            2'h2: dcy_base = `RAGC_DCY_MS2;
            default: dcy_base = `RAGC_DCY_MS3;
        endcase
    end

    // multiplier scaling
    ragc_time_scale u_atk_scale (
        .i_base_ms(atk_base),
        .i_mult_code(attack_reg[`RAGC_MULT_HI:`RAGC_MULT_LO]),
        .o_time_ms(atk_scaled)
    );
    ragc_time_scale u_dcy_scale (
        .i_base_ms(dcy_base),
        .i_mult_code(decay_reg[`RAGC_MULT_HI:`RAGC_MULT_LO]),
        .o_time_ms(dcy_scaled)
    );

    // decay cap by decimation ratio, ratio code is twice ratio minus two
    always @* begin
        case (i_adc_decimation_ratio)
            4'h0: cap_ms = `RAGC_CAP_R10;
            4'h1: cap_ms = `RAGC_CAP_R15;
            4'h2: cap_ms = `RAGC_CAP_R20;
            4'h3: cap_ms = `RAGC_CAP_R25;
            4'h4, 4'h5: cap_ms = `RAGC_CAP_R35;
            4'h6, 4'h7: cap_ms = `RAGC_CAP_R45;
            4'h8: cap_ms = `RAGC_CAP_R50;
            default: cap_ms = `RAGC_CAP_R60;
        endcase
        if (decay_reg[`RAGC_SRC_BIT]) begin
            next_decay = dcy_scaled;
        end else begin
            next_decay = i_legacy_decay_ms;
        end
        if (next_decay > cap_ms) begin
            capped = cap_ms;
        end else begin
            capped = next_decay;
        end
    end

    // attack source select, attack time is never capped
    reg [23:0] next_attack;
    always @* begin
        if (attack_reg[`RAGC_SRC_BIT]) begin
            next_attack = atk_scaled;
        end else begin
            next_attack = i_legacy_attack_ms;
        end
    end

    // read data mux, status byte keeps bit 1 at zero
    reg [7:0] next_rdata;
    always @* begin
        case (i_addr)
            `RAGC_ADDR_ATTACK: next_rdata = attack_reg;
            `RAGC_ADDR_DECAY: next_rdata = decay_reg;
            `RAGC_ADDR_PATH: next_rdata = {path_reg[7:2], 1'b0, err_flag};
            default: next_rdata = 8'h00; // unmapped reads give zero
        endcase
    end

    // bus error synchroniser, two flops before any logic
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_meta <= 1'b0;
            err_sync <= 1'b0;
        end else if (i_ce) begin
            err_meta <= i_bus_error;
            err_sync <= err_meta;
        end
    end

    // register writes, unmapped writes ignored
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            attack_reg <= `RAGC_ATTACK_RESET;
            decay_reg <= `RAGC_DECAY_RESET;
            path_reg <= `RAGC_PATH_RESET;
        end else if (i_ce && i_wr) begin
            // attack and decay low reserved bits stored as written, path low bits forced to 0; software keeps them 0
            case (i_addr)
                `RAGC_ADDR_ATTACK: attack_reg <= i_wdata;
                `RAGC_ADDR_DECAY: decay_reg <= i_wdata;
                `RAGC_ADDR_PATH: path_reg <= {i_wdata[7:2], 2'b00};
                default: ;
            endcase
        end
    end

    // error status flag, set beats the read clear
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_flag <= 1'b0;
        end else if (i_ce) begin
            if (det_on && err_sync) begin
                err_flag <= 1'b1;
            end else if (i_rd && i_addr == `RAGC_ADDR_PATH) begin
                err_flag <= 1'b0;
            end
        end
    end

    // detector clear pulse, one cycle per synced error cycle while the detector is on
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bus_error_clear <= 1'b0;
        end else if (i_ce) begin
            o_bus_error_clear <= det_on && err_sync;
        end
    end

    // read data register, holds until the next read
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_ce && i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // effective attack and decay times
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_attack_ms <= 24'h000000;
            o_decay_ms <= 24'h000000;
        end else if (i_ce) begin
            o_attack_ms <= next_attack;
            o_decay_ms <= capped;
        end
    end

    // filter coefficient, microphone and effects routing
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_left_hpf_prog <= 1'b0;
            o_right_hpf_prog <= 1'b0;
            o_left_analog_mic <= 1'b0;
            o_right_analog_mic <= 1'b0;
            o_effects_after_adc <= 1'b0;
        end else if (i_ce) begin
            o_left_hpf_prog <= path_reg[`RAGC_HPF_LEFT_BIT];
            o_right_hpf_prog <= path_reg[`RAGC_HPF_RIGHT_BIT];
            o_left_analog_mic <= path_reg[`RAGC_DECIM_HI];
            o_right_analog_mic <= path_reg[`RAGC_DECIM_LO];
            o_effects_after_adc <= path_reg[`RAGC_FILT_PATH_BIT]
                && i_dacs_powered_down;
        end
    end
endmodule

// ---- ragc_defs.vh ----
// register offsets, field positions, reset values and timing constants
`ifndef RAGC_DEFS_VH
`define RAGC_DEFS_VH
`define RAGC_ADDR_ATTACK 7'h69
`define RAGC_ADDR_DECAY 7'h6a
`define RAGC_ADDR_PATH 7'h6b
`define RAGC_ATTACK_RESET 8'h00
`define RAGC_DECAY_RESET 8'h00
`define RAGC_PATH_RESET 8'h00
`define RAGC_SRC_BIT 7
`define RAGC_BASE_HI 6
`define RAGC_BASE_LO 5
`define RAGC_MULT_HI 4
`define RAGC_MULT_LO 2
`define RAGC_HPF_LEFT_BIT 7
`define RAGC_HPF_RIGHT_BIT 6
`define RAGC_DECIM_HI 5
`define RAGC_DECIM_LO 4
`define RAGC_FILT_PATH_BIT 3
`define RAGC_DET_OFF_BIT 2
`define RAGC_ERR_BIT 0
// baseline times in ms
`define RAGC_ATK_MS0 16'd7
`define RAGC_ATK_MS1 16'd8
`define RAGC_ATK_MS2 16'd10
`define RAGC_ATK_MS3 16'd11
`define RAGC_DCY_MS0 16'd50
`define RAGC_DCY_MS1 16'd150
`define RAGC_DCY_MS2 16'd250
`define RAGC_DCY_MS3 16'd350
// decay caps in ms, index is twice the decimation ratio minus two
`define RAGC_CAP_R10 24'd4000
`define RAGC_CAP_R15 24'd5600
`define RAGC_CAP_R20 24'd8000
`define RAGC_CAP_R25 24'd9600
`define RAGC_CAP_R35 24'd11200
`define RAGC_CAP_R45 24'd16000
`define RAGC_CAP_R50 24'd19200
`define RAGC_CAP_R60 24'd22400
`endif

// ---- ragc_time_scale.v ----
// baseline time times power-of-two multiplier
`timescale 1ns/1ps
module ragc_time_scale (
    input wire [15:0] i_base_ms,
    input wire [2:0] i_mult_code,
    output wire [23:0] o_time_ms
);
    // shift by code gives factor 1..128
    assign o_time_ms = {8'h00, i_base_ms} << i_mult_code;
endmodule

// ---- ragc_regs_asserts.sv ----
// assertion checker for the right agc timing registers
`timescale 1ns/1ps
module ragc_regs_asserts (
    input wire i_clk, i_nrst, i_ce, i_wr, i_rd, i_dacs_powered_down,
    input wire i_bus_error, o_left_hpf_prog, o_right_hpf_prog,
    input wire o_left_analog_mic, o_right_analog_mic, o_effects_after_adc,
    input wire o_bus_error_clear,
    input wire [6:0] i_addr,
    input wire [7:0] i_wdata, o_rdata,
    input wire [3:0] i_adc_decimation_ratio,
    input wire [23:0] i_legacy_attack_ms, i_legacy_decay_ms, o_attack_ms,
    input wire [23:0] o_decay_ms
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    localparam int caps [11] = '{4000, 5600, 8000, 9600, 11200, 11200,
        16000, 16000, 19200, 22400, 22400};
    // write strobes per register and expected times from the write data
    wire wa = i_ce & i_wr & (i_addr == 7'h69);
    wire wd = i_ce & i_wr & (i_addr == 7'h6a);
    wire wp = i_ce & i_wr & (i_addr == 7'h6b);
    wire [3:0] rq = i_adc_decimation_ratio > 10 ? 4'ha : i_adc_decimation_ratio;
    wire [23:0] cap = 24'(caps[rq]);
    wire [23:0] atk = 24'(7 + i_wdata[6:5] + i_wdata[6]) << i_wdata[4:2];
    wire [23:0] dcy = 24'(50 + 100 * i_wdata[6:5]) << i_wdata[4:2];
    atk_new_a: assert property (wa && i_wdata[7] |-> ##2
        o_attack_ms == $past(atk, 2)) else $error("attack time wrong");
    atk_leg_a: assert property (wa && !i_wdata[7] |-> ##2
        o_attack_ms == i_legacy_attack_ms) else $error("attack source wrong");
    dcy_new_a: assert property (wd && i_wdata[7] |-> ##2
        o_decay_ms == ($past(dcy, 2) < cap ? $past(dcy, 2) : cap))
        else $error("decay time wrong");
    dcy_leg_a: assert property (wd && !i_wdata[7] |-> ##2
        o_decay_ms == i_legacy_decay_ms) else $error("decay source wrong");
    hpf_mic_a: assert property (wp |-> ##2 {o_left_hpf_prog,
        o_right_hpf_prog, o_left_analog_mic, o_right_analog_mic} ==
        $past(i_wdata[7:4], 2)) else $error("filter or mic select wrong");
    fx_path_a: assert property (wp |-> ##2 o_effects_after_adc ==
        ($past(i_wdata[3], 2) & i_dacs_powered_down))
        else $error("effects path wrong");
    err_clr_a: assert property (o_bus_error_clear |->
        $past(i_bus_error, 3) || $past(i_bus_error, 4))
        else $error("bus error clear without error");
    rd_res_a: assert property (i_ce && i_rd && i_addr == 7'h6b |=>
        !o_rdata[1]) else $error("reserved status bit set");
    unmap_rd_a: assert property (i_ce && i_rd && (i_addr < 7'h69 ||
        i_addr > 7'h6b) |=> o_rdata == 8'h00) else $error("unmapped read");
endmodule
bind ragc_regs ragc_regs_asserts u_chk (.*);

// ---- testbench.sv ----
// self-checking bench for the right agc timing registers
`timescale 1ns/1ps
`define CHK(s, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", s, e, g); end end
module testbench;
    reg i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_bus_error = 0;
    reg [6:0] i_addr = 0;
    reg [7:0] i_wdata = 0, a8, d;
    reg [3:0] ratio = 0;
    reg [23:0] e, g;
    wire [7:0] o_rdata;
    wire [23:0] o_attack_ms, o_decay_ms;
    wire [4:0] sel;
    wire clr;
    reg ce = 1, dacs = 1;
    int n_clr = 0;
    int miscompares = 0, n_tests = 0;
    // ratio, address, write data, expected time or select bits
    reg [43:0] rows [14] = '{44'h0_69_00_000123, 44'h0_69_80_000007,
        44'h0_69_bc_000400, 44'h0_69_c8_000028, 44'h0_69_e0_00000b,
        44'h0_6a_00_000456, 44'h0_6a_80_000032, 44'h0_6a_bc_000fa0,
        44'ha_6a_fc_005780, 44'h3_6a_d4_001f40, 44'h0_6b_88_000011,
        44'h0_6b_5c_00000b, 44'h0_6b_20_000004, 44'h0_6b_34_000006};
    ragc_regs u_dut (.i_clk, .i_nrst, .i_ce(ce), .i_addr, .i_wr, .i_rd,
        .i_wdata, .i_legacy_attack_ms(24'h123), .i_legacy_decay_ms(24'h456),
        .i_adc_decimation_ratio(ratio), .i_dacs_powered_down(dacs),
        .i_bus_error, .o_rdata, .o_attack_ms, .o_decay_ms,
        .o_left_hpf_prog(sel[4]), .o_right_hpf_prog(sel[3]),
        .o_left_analog_mic(sel[2]), .o_right_analog_mic(sel[1]),
        .o_effects_after_adc(sel[0]), .o_bus_error_clear(clr));
    always #5 i_clk = ~i_clk;
    // count detector clear pulses
    always @(posedge i_clk) n_clr <= n_clr + clr;
    // one register access, strobe for one edge, then address and data held two edges more
    task automatic acc(input w, input [6:0] a, input [7:0] v);
        i_wr = w;
        i_rd = !w;
        i_addr = a;
        i_wdata = v;
        @(posedge i_clk) #1;
        i_wr = 0;
        i_rd = 0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    // one cycle error pulse, then time for the synchroniser
    task automatic err_pulse;
        i_bus_error = 1;
        @(posedge i_clk) #1;
        i_bus_error = 0;
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    task report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_nrst = 1;
        @(posedge i_clk) #1;
        foreach (rows[i]) begin
            {ratio, a8, d, e} = rows[i];
            acc(1, a8[6:0], d);
            g = a8 == 8'h69 ? o_attack_ms : a8 == 8'h6a ? o_decay_ms : sel;
            `CHK("output", e, g)
            acc(0, a8[6:0], 8'h00);
            `CHK("readback", a8 == 8'h6b ? d & 8'hfc : d, o_rdata)
            $display("row %0d done", i);
        end
        ce = 0;
        acc(1, 7'h69, 8'h80);
        ce = 1;
        acc(0, 7'h69, 8'h00);
        `CHK("frozen write", 8'he0, o_rdata)
        `CHK("frozen attack", 24'h00000b, o_attack_ms)
        acc(1, 7'h6b, 8'h00);
        err_pulse;
        `CHK("clear pulse", 1, n_clr)
        acc(0, 7'h6b, 8'h00);
        `CHK("error set", 8'h01, o_rdata)
        acc(0, 7'h6b, 8'h00);
        `CHK("error cleared", 8'h00, o_rdata)
        acc(1, 7'h6b, 8'h04);
        err_pulse;
        acc(0, 7'h6b, 8'h00);
        `CHK("detector off", 8'h04, o_rdata)
        `CHK("no clear pulse", 1, n_clr)
        dacs = 0;
        acc(1, 7'h6b, 8'h08);
        `CHK("dacs on path", 5'h00, sel)
        dacs = 1;
        acc(1, 7'h6c, 8'hff);
        acc(0, 7'h6c, 8'h00);
        `CHK("unmapped", 8'h00, o_rdata)
        $display("error and unmapped tests done");
        i_nrst = 0;
        @(posedge i_clk) #1;
        i_nrst = 1;
        acc(0, 7'h6a, 8'h00);
        `CHK("decay reset", 8'h00, o_rdata)
        `CHK("legacy decay", 24'h000456, o_decay_ms)
        $display("reset test done");
        report_and_stop;
    end
endmodule
